/* File: rtl/sscr_regs.v */
// Purpose: Configuration and status registers of a swipe sensor scanner
// Assumes: Host register messages are decoded to a plain strobe port
// Notes:   Pin outputs reset only by the power-on reset pin
`timescale 1ns/1ps
`include "sscr_consts.vh"

module sscr_regs (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire        sw_master_rst_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  input  wire        meas_bias1_in,
  input  wire [1:0]  meas_bias_auto1_in,
  input  wire [1:0]  meas_bias_auto2_in,
  input  wire        buf_full_in,
  input  wire        hist_hold_in,
  input  wire        finger_timer_in,
  input  wire [3:0]  scan_state_in,
  input  wire        nav_mode_in,
  input  wire        nav_finger_in,
  input  wire [3:0]  nav_dir_in,
  input  wire [3:0]  gen_pin_in,
  input  wire        bus_serial_sel_in,
  output reg  [6:0]  demod_phase_hi_out,
  output reg  [1:0]  gain1_out,
  output reg  [1:0]  gain2_out,
  output reg  [1:0]  bias1_out,
  output reg  [1:0]  bias2_out,
  output reg         null_en_out,
  output reg  [5:0]  null_level_out,
  output reg  [6:0]  ref_hi_out,
  output reg  [6:0]  ref_lo_out,
  output reg  [7:0]  scan_first_col_out,
  output reg  [7:0]  scan_last_col_out,
  output reg         low_res_out,
  output reg  [1:0]  pix_pack_out,
  output reg  [3:0]  bin_thresh_out,
  output reg         test_regs_en_out,
  output reg         regs_first_out,
  output reg         hist_full_out,
  output reg         hist_msg_en_out,
  output reg         img_msg_en_out,
  output reg  [31:14] challenge_out,
  output reg  [3:0]  gen_pin_out,
  output reg  [3:0]  gen_pin_oe_out,
  output reg  [3:0]  product_id_out
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  [7:0] gain_r;
  reg  [7:0] bias_r;
  reg  [6:0] null_r;
  reg  [6:0] start_col_r;
  reg  [6:0] end_col_r;
  reg  [6:0] res_r;
  reg  [4:0] msg_r;
  reg  [3:0] pins_r;
  reg        pwr_cyc_r;
  reg        paused_r;
  reg        rst_seen_r;
  reg  [8:0] last_col_nxt;
  reg  [7:0] rdata_nxt;
  wire       soft_rst;
  wire       wr_hit;
  wire       stat_rd;

  // Software master reset restores configuration but never the pins
  assign soft_rst = rst_in | sw_master_rst_in;
  assign wr_hit   = reg_wr_in;
  assign stat_rd  = reg_rd_in & (reg_addr_in == `SSCR_A_STATUS);

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (soft_rst) begin
      demod_phase_hi_out <= `SSCR_RST_PHASE_UP;
      gain_r      <= 8'h00;
      bias_r      <= 8'h00;
      null_r      <= 7'h00;
      ref_hi_out  <= `SSCR_RST_REF_HI;
      ref_lo_out  <= `SSCR_RST_REF_LO;
      start_col_r <= 7'h00;
      end_col_r   <= `SSCR_RST_END_COL;
      res_r       <= {3'b000, `SSCR_RST_THRESH};
      msg_r       <= `SSCR_RST_MSG;
      challenge_out <= {11'h000, `SSCR_RST_CHAL_C};
    end else if (wr_hit) begin
      case (reg_addr_in)
        `SSCR_A_PHASE_UP:  demod_phase_hi_out <= reg_wdata_in[6:0];
        `SSCR_A_GAIN:      gain_r <= reg_wdata_in & 8'h33;
        `SSCR_A_BIAS:      bias_r <= reg_wdata_in & 8'h77;
        `SSCR_A_NULL:      null_r <= reg_wdata_in[6:0];
        `SSCR_A_REF_HI:    ref_hi_out <= reg_wdata_in[6:0];
        `SSCR_A_REF_LO:    ref_lo_out <= reg_wdata_in[6:0];
        `SSCR_A_START_COL: start_col_r <= reg_wdata_in[6:0];
        `SSCR_A_END_COL:   end_col_r <= reg_wdata_in[6:0];
        `SSCR_A_RES:       res_r <= reg_wdata_in[6:0];
        `SSCR_A_MSG:       msg_r <= {reg_wdata_in[5:3], reg_wdata_in[1:0]};
        `SSCR_A_CHAL_A:    challenge_out[31:28] <= reg_wdata_in[3:0];
        `SSCR_A_CHAL_B:    challenge_out[27:21] <= reg_wdata_in[6:0];
        `SSCR_A_CHAL_C:    challenge_out[20:14] <= reg_wdata_in[6:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Decoded control outputs
  // --------------------------------------------------------------------
  always @* begin
    last_col_nxt = {end_col_r, `SSCR_COL_END_LSB};
  end

  always @(posedge sys_clk_in) begin
    if (soft_rst) begin
      gain1_out <= 2'b00;
      gain2_out <= 2'b00;
      bias1_out <= 2'b00;
      bias2_out <= 2'b00;
      null_en_out <= 1'b0;
      null_level_out <= 6'h00;
      scan_first_col_out <= 8'h00;
      scan_last_col_out  <= `SSCR_COL_MAX;
      low_res_out  <= 1'b0;
      pix_pack_out <= `SSCR_RES_PIX4;
      bin_thresh_out <= `SSCR_RST_THRESH;
      test_regs_en_out <= 1'b1;
      regs_first_out   <= 1'b0;
      hist_full_out    <= 1'b0;
      hist_msg_en_out  <= 1'b0;
      img_msg_en_out   <= 1'b1;
    end else begin
      gain1_out <= gain_r[1:0];
      gain2_out <= gain_r[5:4];
      // Unlocked stage follows measure frequency table
      bias1_out <= bias_r[2] ? bias_r[1:0] : meas_bias_auto1_in;
      bias2_out <= bias_r[6] ? bias_r[5:4] : meas_bias_auto2_in;
      null_en_out <= null_r[6];
      null_level_out <= null_r[5:0];
      scan_first_col_out <= {start_col_r[5:0], `SSCR_COL_START_LSB};
      if (last_col_nxt > {1'b0, `SSCR_COL_MAX}) begin
        scan_last_col_out <= `SSCR_COL_MAX;
      end else begin
        scan_last_col_out <= last_col_nxt[7:0];
      end
      low_res_out  <= res_r[6];
      pix_pack_out <= res_r[5:4];
      bin_thresh_out <= res_r[3:0];
      test_regs_en_out <= msg_r[`SSCR_MSG_TEST];
      regs_first_out   <= msg_r[`SSCR_MSG_REGFIRST];
      hist_full_out    <= msg_r[`SSCR_MSG_FULLHIST];
      hist_msg_en_out  <= msg_r[`SSCR_MSG_HIST_EN];
      img_msg_en_out   <= ~msg_r[`SSCR_MSG_IMG_DIS];
    end
  end

  // --------------------------------------------------------------------
  // General pins, touched by the reset pin only
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      pins_r <= 4'h0;
      gen_pin_out <= 4'h0;
      gen_pin_oe_out <= 4'h0;
      rst_seen_r <= 1'b1;
    end else begin
      rst_seen_r <= 1'b0;
      if (wr_hit && reg_addr_in == `SSCR_A_PINS) begin
        pins_r <= reg_wdata_in[3:0];
      end
      gen_pin_out <= pins_r;
      gen_pin_oe_out <= 4'hF;
    end
  end

  // Identity caught on the first edge after reset release when bus_serial_sel_in is set
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      product_id_out <= 4'h0;
    end else if (rst_seen_r && bus_serial_sel_in) begin
      product_id_out <= gen_pin_in;
    end
  end

  // --------------------------------------------------------------------
  // Sticky status; a new event beats the read that clears it
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      pwr_cyc_r <= 1'b1;
      paused_r  <= 1'b0;
    end else begin
      if (stat_rd) begin
        pwr_cyc_r <= 1'b0;
      end
      paused_r <= (buf_full_in | hist_hold_in) | (paused_r & ~stat_rd);
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_in)
      `SSCR_A_PHASE_UP:  rdata_nxt = {1'b0, demod_phase_hi_out};
      `SSCR_A_GAIN:      rdata_nxt = gain_r;
      `SSCR_A_BIAS:      rdata_nxt = bias_r;
      `SSCR_A_NULL:      rdata_nxt = {1'b0, null_r};
      `SSCR_A_REF_HI:    rdata_nxt = {1'b0, ref_hi_out};
      `SSCR_A_REF_LO:    rdata_nxt = {1'b0, ref_lo_out};
      `SSCR_A_START_COL: rdata_nxt = {1'b0, start_col_r};
      `SSCR_A_END_COL:   rdata_nxt = {1'b0, end_col_r};
      `SSCR_A_RES:       rdata_nxt = {1'b0, res_r};
      `SSCR_A_MSG:       rdata_nxt = {2'b00, msg_r[4:2], 1'b0, msg_r[1:0]};
      `SSCR_A_PINS:      rdata_nxt = {4'h0, pins_r};
      `SSCR_A_STATUS:    rdata_nxt = {1'b0, pwr_cyc_r, paused_r,
                                      finger_timer_in, scan_state_in};
      `SSCR_A_CHAL_A:    rdata_nxt = nav_mode_in ?
                           {3'b000, nav_finger_in, nav_dir_in} : 8'h00;
      default:           rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

/* File: rtl/sscr_consts.vh */
// Purpose: Constants for the scan configuration and status register bank
// Assumes: Byte-wide registers at their printed byte offsets
// Notes:   Included by sscr_regs.v only
`ifndef SSCR_CONSTS_VH
`define SSCR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSCR_A_PHASE_UP   8'h8C
`define SSCR_A_GAIN       8'h8E
`define SSCR_A_BIAS       8'h8F
`define SSCR_A_NULL       8'h90
`define SSCR_A_REF_HI     8'h91
`define SSCR_A_REF_LO     8'h92
`define SSCR_A_START_COL  8'h95
`define SSCR_A_END_COL    8'h96
`define SSCR_A_RES        8'h97
`define SSCR_A_MSG        8'h98
`define SSCR_A_PINS       8'h99
`define SSCR_A_STATUS     8'h9A
`define SSCR_A_CHAL_A     8'h9B
`define SSCR_A_CHAL_B     8'h9C
`define SSCR_A_CHAL_C     8'h9D
`define SSCR_A_TEST_LAST  8'h9F

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSCR_RST_PHASE_UP 7'h40
`define SSCR_RST_REF_HI   7'h70
`define SSCR_RST_REF_LO   7'h20
`define SSCR_RST_END_COL  7'h7F
`define SSCR_RST_THRESH   4'h8
`define SSCR_RST_MSG      5'h10
`define SSCR_RST_CHAL_C   7'h06

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define SSCR_MSG_TEST     4
`define SSCR_MSG_REGFIRST 3
`define SSCR_MSG_FULLHIST 2
`define SSCR_MSG_HIST_EN  1
`define SSCR_MSG_IMG_DIS  0
`define SSCR_RES_PIX4     2'b00
`define SSCR_RES_PIX1     2'b01
`define SSCR_COL_MAX      8'hBF
`define SSCR_COL_END_LSB  2'b11
`define SSCR_COL_START_LSB 2'b00
`endif

/* File: verif/sscr_sense_model.sv */
// Purpose: Far-side model of the pins and the scan core feeding the bank
// Assumes: Board straps pull each general pin while it is not driven
// Notes:   One stall request gives a one-cycle buffer-full blip
`timescale 1ns/1ps
module sscr_sense_model (
  input  logic       sys_clk_in,
  input  logic [3:0] pin_out_in,
  input  logic [3:0] pin_oe_in,
  input  logic [3:0] strap_in,
  input  logic       stall_req_in,
  output logic [3:0] pin_level_out,
  output logic       buf_full_out
);
  // Straps win only where the bank lets go of the pin
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & strap_in);
  always @(posedge sys_clk_in) begin
    buf_full_out <= stall_req_in;
  end
endmodule

/* File: verif/sscr_regs_assertions.sv */
// Purpose: Port timing checks on the scan config register bank
// Assumes: Read data one cycle after the strobe, raw regs one edge later
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module sscr_checker (
  input logic        sys_clk_in,
  input logic        rst_in,
  input logic        sw_master_rst_in,
  input logic [7:0]  reg_addr_in,
  input logic [7:0]  reg_wdata_in,
  input logic        reg_wr_in,
  input logic        reg_rd_in,
  input logic [7:0]  reg_rdata_out,
  input logic [3:0]  scan_state_in,
  input logic        nav_mode_in,
  input logic        nav_finger_in,
  input logic [3:0]  nav_dir_in,
  input logic [6:0]  demod_phase_hi_out,
  input logic [6:0]  ref_hi_out,
  input logic [7:0]  scan_first_col_out,
  input logic [7:0]  scan_last_col_out,
  input logic [31:14] challenge_out,
  input logic [3:0]  gen_pin_out,
  input logic [3:0]  gen_pin_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its slot");
  chk_status_read: assert property ($past(reg_rd_in) &&
    $past(reg_addr_in) == 8'h9A |-> !reg_rdata_out[7] &&
    reg_rdata_out[3:0] == $past(scan_state_in)) else $error("bad status");
  chk_nav_read: assert property ($past(reg_rd_in) &&
    $past(reg_addr_in) == 8'h9B && $past(nav_mode_in) |-> reg_rdata_out ==
    {3'h0, $past(nav_finger_in), $past(nav_dir_in)}) else $error("bad nav");
  chk_pins_off: assert property (disable iff (1'b0) rst_in ##1 rst_in
    |-> gen_pin_out == 4'h0 && gen_pin_oe_out == 4'h0) else $error("pins on");
  chk_pins_drive: assert property (!$past(rst_in) |-> gen_pin_oe_out == 4'hF)
    else $error("pins not driven");
  chk_phase_write: assert property (reg_wr_in && reg_addr_in == 8'h8C &&
    !sw_master_rst_in |=> demod_phase_hi_out == $past(reg_wdata_in[6:0]))
    else $error("phase not written");
  chk_ref_write: assert property (reg_wr_in && reg_addr_in == 8'h91 &&
    !sw_master_rst_in |=> ref_hi_out == $past(reg_wdata_in[6:0]))
    else $error("ref not written");
  chk_chal_write: assert property (reg_wr_in && reg_addr_in == 8'h9B &&
    !sw_master_rst_in |=> challenge_out[31:28] == $past(reg_wdata_in[3:0]))
    else $error("challenge not written");
  chk_col_shape: assert property (scan_first_col_out[1:0] == 2'h0 &&
    scan_last_col_out[1:0] == 2'h3 && scan_last_col_out <= 8'hBF)
    else $error("bad column");
endmodule
bind sscr_regs sscr_checker sscr_checker_i (.*);

/* File: verif/tb.sv */
// Purpose: Register-level bench for the scan config register bank
// Assumes: Decoded outputs settle two edges after a write
// Notes:   Pins go through the far-side model with straps 9h
`timescale 1ns/1ps
module tb;
  logic sys_clk_in = 0, rst_in = 1, sw_master_rst_in = 0, reg_wr_in = 0;
  logic reg_rd_in = 0, hist_hold_in = 0, finger_timer_in = 0, nav_mode_in = 0;
  logic nav_finger_in = 0, bus_serial_sel_in = 1, meas_bias1_in = 0, stall = 0;
  logic [7:0] reg_addr_in = '0, reg_wdata_in = '0;
  logic [1:0] meas_bias_auto1_in = 2'h2, meas_bias_auto2_in = 2'h1;
  logic [3:0] scan_state_in = '0, nav_dir_in = '0;
  wire [7:0] reg_rdata_out, scan_first_col_out, scan_last_col_out;
  wire [6:0] demod_phase_hi_out, ref_hi_out, ref_lo_out;
  wire [1:0] gain1_out, gain2_out, bias1_out, bias2_out, pix_pack_out;
  wire [5:0] null_level_out;
  wire [3:0] bin_thresh_out, gen_pin_out, gen_pin_oe_out, product_id_out;
  wire [3:0] gen_pin_in;
  wire [31:14] challenge_out;
  wire null_en_out, low_res_out, test_regs_en_out, regs_first_out;
  wire hist_full_out, hist_msg_en_out, img_msg_en_out, buf_full_in;
  int bad_count = 0, comparisons = 0;
  localparam logic [239:0] RV = {16'h8C40, 16'h8E00, 16'h8F00, 16'h9000,
    16'h9170, 16'h9220, 16'h9500, 16'h967F, 16'h9708, 16'h9820, 16'h9900,
    16'h9B00, 16'h9C00, 16'h9D00, 16'h8000};
  localparam logic [239:0] WM = {16'h8C7F, 16'h8E33, 16'h8F77, 16'h907F,
    16'h917F, 16'h927F, 16'h957F, 16'h967F, 16'h977F, 16'h983B, 16'h990F,
    16'h9A00, 16'h9B00, 16'h9C00, 16'h9D00};
  sscr_regs sscr_regs_i (.*);
  sscr_sense_model sscr_sense_model_i (.sys_clk_in(sys_clk_in),
    .pin_out_in(gen_pin_out), .pin_oe_in(gen_pin_oe_out), .strap_in(4'h9),
    .stall_req_in(stall), .pin_level_out(gen_pin_in),
    .buf_full_out(buf_full_in));
  always #20 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= ad;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= ad;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge sys_clk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic por;
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk({gen_pin_oe_out, gen_pin_out}, 8'h00);
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic conclude;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    por();
    rd(8'h9A, 8'h40);
    rd(8'h9A, 8'h00);
    for (int i = 0; i < 15; i++) rd(RV[i*16+8 +: 8], RV[i*16 +: 8]);
    chk({challenge_out[20:14], product_id_out}, 11'h069);
    $display("reset values done");
    for (int i = 0; i < 15; i++) begin
      wr(WM[i*16+8 +: 8], 8'hFF);
      rd(WM[i*16+8 +: 8], WM[i*16 +: 8]);
    end
    chk({challenge_out, demod_phase_hi_out}, 25'h1FF_FFFF);
    @(posedge sys_clk_in);
    sw_master_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    sw_master_rst_in <= 1'b0;
    rd(8'h8C, 8'h40);
    chk({gen_pin_out, ref_hi_out, ref_lo_out}, 18'h3_F820);
    chk({scan_last_col_out, bin_thresh_out}, 12'hBF8);
    $display("masks and master reset done");
    for (int g = 0; g < 4; g++) begin
      wr(8'h8E, 8'(g * 16 + 3 - g));
      chk({gain2_out, gain1_out}, g * 4 + 3 - g);
    end
    wr(8'h8F, 8'h05);
    chk({bias2_out, bias1_out}, 4'h5);
    wr(8'h8F, 8'h60);
    chk({bias2_out, bias1_out}, 4'hA);
    wr(8'h90, 8'h45);
    chk({null_en_out, null_level_out}, 7'h45);
    wr(8'h91, 8'h13);
    wr(8'h92, 8'h05);
    chk({ref_hi_out, ref_lo_out}, 14'h0985);
    wr(8'h95, 8'h05);
    chk(scan_first_col_out, 8'h14);
    for (int e = 46; e < 49; e++) begin
      wr(8'h96, 8'(e));
      chk(scan_last_col_out, e > 47 ? 191 : e * 4 + 3);
    end
    wr(8'h97, 8'h15);
    chk({low_res_out, pix_pack_out, bin_thresh_out}, 7'h15);
    wr(8'h97, 8'h40);
    chk({low_res_out, pix_pack_out, bin_thresh_out}, 7'h40);
    wr(8'h98, 8'h3B);
    chk({test_regs_en_out, regs_first_out, hist_full_out, hist_msg_en_out,
      img_msg_en_out}, 5'h1E);
    wr(8'h98, 8'h00);
    chk({test_regs_en_out, regs_first_out, hist_full_out, hist_msg_en_out,
      img_msg_en_out}, 5'h01);
    wr(8'h99, 8'h0A);
    chk({gen_pin_oe_out, gen_pin_out, gen_pin_in}, 12'hFAA);
    $display("decode done");
    for (int s = 0; s < 16; s++) begin
      @(posedge sys_clk_in);
      scan_state_in   <= 4'(s);
      finger_timer_in <= s[0];
      rd(8'h9A, 8'(s % 2 * 16 + s));
    end
    @(posedge sys_clk_in);
    stall <= 1'b1;
    @(posedge sys_clk_in);
    stall <= 1'b0;
    rd(8'h9A, 8'h3F);
    rd(8'h9A, 8'h1F);
    @(posedge sys_clk_in);
    hist_hold_in <= 1'b1;
    @(posedge sys_clk_in);
    hist_hold_in <= 1'b0;
    rd(8'h9A, 8'h3F);
    rd(8'h9A, 8'h1F);
    @(posedge sys_clk_in);
    nav_mode_in   <= 1'b1;
    nav_finger_in <= 1'b1;
    nav_dir_in    <= 4'h6;
    rd(8'h9B, 8'h16);
    @(posedge sys_clk_in);
    nav_finger_in <= 1'b0;
    nav_dir_in    <= 4'h0;
    rd(8'h9B, 8'h00);
    $display("status and navigation done");
    por();
    rd(8'h9A, 8'h5F);
    chk({gen_pin_oe_out, gen_pin_out, product_id_out}, 12'hF09);
    $display("power reset done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    conclude();
  end
endmodule
